// >>> hw/integrity_consts.svh
// register offsets, field positions and reset values of the input link integrity checker
// Notes on behaviour
// - port 1 rising compare errors, bits 13..8, sit in upper status bits 5..0; 7..6 zero
// - port 0 falling compare errors: bits 7..0 low register, 13..8 upper register; read-only
// - port 1 falling compare errors: bits 7..0 low register, 13..8 upper; upper bits reserved
// - parity checked only while parity control bit 7 set; host enables frame parity elsewhere
// - sense bit 6 set: parity bit one means data word has even ones
// - sense bit 6 clear: parity bit one means data word has odd ones
// - writing one to parity control bit 5 zeroes both parity error counters
// - status bit 1 set on parity mismatch of a falling edge word
// - status bit 0 set on parity mismatch of a rising edge word
// - per-bit sample compare runs only while compare control bit 7 set
// - writing one to compare control bit 6 clears all compare error flags
// - separate 8-bit rising and falling parity error counts, saturating not wrapping
`ifndef INTEGRITY_CONSTS_SVH
`define INTEGRITY_CONSTS_SVH

// ************************************************************
// widths
// ************************************************************
`define SAMPLE_W 14
`define REG_ADDR_W 7

// ************************************************************
// register offsets
// ************************************************************
`define ADDR_CMP_CTRL 7'h50
`define ADDR_CMP_P0_RISE_LO 7'h51
`define ADDR_CMP_P0_RISE_HI 7'h52
`define ADDR_CMP_P1_RISE_LO 7'h53
`define ADDR_CMP_P1_RISE_HI 7'h54
`define ADDR_CMP_P0_FALL_LO 7'h55
`define ADDR_CMP_P0_FALL_HI 7'h56
`define ADDR_CMP_P1_FALL_LO 7'h57
`define ADDR_CMP_P1_FALL_HI 7'h58
`define ADDR_PAR_CTRL 7'h5c
`define ADDR_PAR_CNT_RISE 7'h5d
`define ADDR_PAR_CNT_FALL 7'h5e

// ************************************************************
// field positions
// ************************************************************
`define CMP_EN_BIT 7
`define CMP_CLR_BIT 6
`define CMP_FAIL_BIT 0
`define PAR_EN_BIT 7
`define PAR_EVEN_BIT 6
`define PAR_CLR_BIT 5
`define PAR_ERR_FALL_BIT 1
`define PAR_ERR_RISE_BIT 0

// ************************************************************
// reset values
// ************************************************************
`define CMP_CTRL_RST 8'h00
`define PAR_CTRL_RST 8'h00
`define CMP_ERR_RST 14'h0000
`define PAR_CNT_RST 8'h00
`define PAR_CNT_MAX 8'hff

`endif

// >>> hw/integrity_pkg.sv
// types shared by the input link integrity checker
package integrity_pkg;
   typedef logic [13:0] sample_t;
   typedef enum logic [1:0] {st_idle, st_instr, st_data} spi_state_e;
endpackage : integrity_pkg

// >>> hw/serial_reg_port.sv
// serial register port: 8-bit instruction (read flag, 7-bit address) then one data byte
`timescale 1ns/1ps
`include "integrity_consts.svh"
module serial_reg_port import integrity_pkg::*; (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic spi_clk,
   input wire logic spi_cs_n,
   input wire logic spi_sdio_in,
   output logic spi_sdio_out,
   output logic spi_sdio_oe,
   output logic [`REG_ADDR_W-1:0] reg_addr,
   output logic [7:0] reg_wdata,
   output logic reg_wr,
   input wire logic [7:0] reg_rdata
);
   // ************************************************************
   // pin synchronisers: a change counts once stages two and three agree
   // ************************************************************
   logic [2:0] s1_q, s2_q, s3_q, st_q, st_d;
   logic sck_prev_q;
   assign st_d = (s2_q ~^ s3_q) & s3_q | (s2_q ^ s3_q) & st_q;
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         // idle levels (select high, clock low) so no false clock edge follows reset
         s1_q <= 3'h4;
         s2_q <= 3'h4;
         s3_q <= 3'h4;
         st_q <= 3'h4;
         sck_prev_q <= 1'b0;
      end else begin
         s1_q <= {spi_cs_n, spi_sdio_in, spi_clk};
         s2_q <= s1_q;
         s3_q <= s2_q;
         st_q <= st_d;
         sck_prev_q <= st_q[0];
      end
   end
   logic sck_rise, sck_fall, di, cs_idle;
   assign sck_rise = st_q[0] & ~sck_prev_q;
   assign sck_fall = ~st_q[0] & sck_prev_q;
   assign di = st_q[1];
   assign cs_idle = st_q[2];

   // ************************************************************
   // transfer sequencer
   // ************************************************************
   spi_state_e state_q, state_d;
   logic [3:0] cnt_q, cnt_d;
   logic [7:0] sr_q, sr_d, osr_q, osr_d, wdata_q, wdata_d;
   logic [`REG_ADDR_W-1:0] addr_q, addr_d;
   logic rw_q, rw_d, loaded_q, loaded_d, do_q, do_d, oe_q, oe_d, wr_q, wr_d;

   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q;
      sr_d = sr_q;
      osr_d = osr_q;
      wdata_d = wdata_q;
      addr_d = addr_q;
      rw_d = rw_q;
      loaded_d = loaded_q;
      do_d = do_q;
      oe_d = oe_q;
      wr_d = 1'b0;
      if (cs_idle) begin
         state_d = st_idle;
         cnt_d = 4'h0;
         loaded_d = 1'b0;
         oe_d = 1'b0;
      end else begin
         unique case (state_q)
            st_idle: begin
               state_d = st_instr;
               cnt_d = 4'h0;
            end
            st_instr: begin
               if (sck_rise) begin
                  sr_d = {sr_q[6:0], di};
                  cnt_d = cnt_q + 4'h1;
                  if (cnt_q == 4'h7) begin
                     rw_d = sr_q[6];
                     addr_d = {sr_q[5:0], di};
                     cnt_d = 4'h0;
                     state_d = st_data;
                  end
               end
            end
            st_data: begin
               if (sck_rise && cnt_q < 4'h8) begin
                  sr_d = {sr_q[6:0], di};
                  cnt_d = cnt_q + 4'h1;
                  if (cnt_q == 4'h7 && !rw_q) begin
                     wr_d = 1'b1;
                     wdata_d = {sr_q[6:0], di};
                  end
               end
               // read data leaves on falling edges so the master samples it on rising ones
               if (sck_fall && rw_q && cnt_q < 4'h8) begin
                  if (!loaded_q) begin
                     do_d = reg_rdata[7];
                     osr_d = {reg_rdata[6:0], 1'b0};
                     loaded_d = 1'b1;
                     oe_d = 1'b1;
                  end else begin
                     do_d = osr_q[7];
                     osr_d = {osr_q[6:0], 1'b0};
                  end
               end
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         state_q <= st_idle;
         cnt_q <= 4'h0;
         sr_q <= 8'h00;
         osr_q <= 8'h00;
         wdata_q <= 8'h00;
         addr_q <= 7'h00;
         rw_q <= 1'b0;
         loaded_q <= 1'b0;
         do_q <= 1'b0;
         oe_q <= 1'b0;
         wr_q <= 1'b0;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         sr_q <= sr_d;
         osr_q <= osr_d;
         wdata_q <= wdata_d;
         addr_q <= addr_d;
         rw_q <= rw_d;
         loaded_q <= loaded_d;
         do_q <= do_d;
         oe_q <= oe_d;
         wr_q <= wr_d;
      end
   end

   assign spi_sdio_out = do_q;
   assign spi_sdio_oe = oe_q;
   assign reg_addr = addr_q;
   assign reg_wdata = wdata_q;
   assign reg_wr = wr_q;
endmodule : serial_reg_port

// >>> hw/dac_input_link_integrity_check.sv
// sample compare and parity checking of the dual-port ddr sample input, with its registers
`timescale 1ns/1ps
`include "integrity_consts.svh"
module dac_input_link_integrity_check import integrity_pkg::*; (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic link_clk,
   input wire logic [`SAMPLE_W-1:0] port0_data,
   input wire logic [`SAMPLE_W-1:0] port1_data,
   input wire logic port0_frame_parity_pin,
   input wire logic port1_frame_parity_pin,
   input wire logic [`SAMPLE_W-1:0] expect_rise_pattern,
   input wire logic [`SAMPLE_W-1:0] expect_fall_pattern,
   input wire logic spi_clk,
   input wire logic spi_cs_n,
   input wire logic spi_sdio_in,
   output logic spi_sdio_out,
   output logic spi_sdio_oe
);
   // ************************************************************
   // functions
   // ************************************************************
   // even sense: parity bit one means even ones; odd sense: parity bit one means odd ones
   function automatic logic parity_mismatch(input sample_t word, input logic par_bit, input logic even);
      logic ones_odd;
      ones_odd = ^word;
      parity_mismatch = even ? (par_bit == ones_odd) : (par_bit != ones_odd);
   endfunction : parity_mismatch

   function automatic logic is_addr(input logic [`REG_ADDR_W-1:0] a, input logic [`REG_ADDR_W-1:0] ref_a);
      is_addr = (a == ref_a);
   endfunction : is_addr

   // ************************************************************
   // register port
   // ************************************************************
   logic [`REG_ADDR_W-1:0] reg_addr;
   logic [7:0] reg_wdata;
   logic reg_wr;
   logic [7:0] reg_rdata;

   serial_reg_port u_port (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .spi_clk(spi_clk),
      .spi_cs_n(spi_cs_n),
      .spi_sdio_in(spi_sdio_in),
      .spi_sdio_out(spi_sdio_out),
      .spi_sdio_oe(spi_sdio_oe),
      .reg_addr(reg_addr),
      .reg_wdata(reg_wdata),
      .reg_wr(reg_wr),
      .reg_rdata(reg_rdata)
   );

   // ************************************************************
   // link synchronisers
   // ************************************************************
   // data and frame bits pass the same three stages as the link clock so that a word
   // and the edge that marks it stay aligned; the host must hold them around each edge
   localparam int LINK_W = 2 * `SAMPLE_W + 3;
   logic [LINK_W-1:0] link_raw;
   logic [LINK_W-1:0] link_s1_q, link_s2_q, link_s3_q, link_st_q, link_st_d;
   assign link_raw = {link_clk, port1_frame_parity_pin, port0_frame_parity_pin, port1_data, port0_data};

   genvar g;
   for (g = 0; g < LINK_W; g++) begin : g_sync
      assign link_st_d[g] = (link_s2_q[g] == link_s3_q[g]) ? link_s3_q[g] : link_st_q[g];
   end

   logic link_prev_q;
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         link_s1_q <= '0;
         link_s2_q <= '0;
         link_s3_q <= '0;
         link_st_q <= '0;
         link_prev_q <= 1'b0;
      end else begin
         link_s1_q <= link_raw;
         link_s2_q <= link_s1_q;
         link_s3_q <= link_s2_q;
         link_st_q <= link_st_d;
         link_prev_q <= link_st_q[LINK_W-1];
      end
   end

   sample_t word0, word1;
   logic frm0, frm1, rise_ev, fall_ev;
   assign word0 = link_st_q[`SAMPLE_W-1:0];
   assign word1 = link_st_q[2*`SAMPLE_W-1:`SAMPLE_W];
   assign frm0 = link_st_q[2*`SAMPLE_W];
   assign frm1 = link_st_q[2*`SAMPLE_W+1];
   assign rise_ev = link_st_q[LINK_W-1] & ~link_prev_q;
   assign fall_ev = ~link_st_q[LINK_W-1] & link_prev_q;

   // ************************************************************
   // control registers
   // ************************************************************
   logic cmp_en_q, cmp_en_d, par_en_q, par_en_d, par_even_q, par_even_d;
   logic wr_cmp_ctrl, wr_par_ctrl, cmp_clr, par_clr;
   assign wr_cmp_ctrl = reg_wr & is_addr(reg_addr, `ADDR_CMP_CTRL);
   assign wr_par_ctrl = reg_wr & is_addr(reg_addr, `ADDR_PAR_CTRL);
   // clear bits act on the write itself and read back as zero
   assign cmp_clr = wr_cmp_ctrl & reg_wdata[`CMP_CLR_BIT];
   assign par_clr = wr_par_ctrl & reg_wdata[`PAR_CLR_BIT];

   always_comb begin
      cmp_en_d = cmp_en_q;
      par_en_d = par_en_q;
      par_even_d = par_even_q;
      if (wr_cmp_ctrl) begin
         cmp_en_d = reg_wdata[`CMP_EN_BIT];
      end
      if (wr_par_ctrl) begin
         par_en_d = reg_wdata[`PAR_EN_BIT];
         par_even_d = reg_wdata[`PAR_EVEN_BIT];
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         cmp_en_q <= 1'(`CMP_CTRL_RST >> `CMP_EN_BIT);
         par_en_q <= 1'(`PAR_CTRL_RST >> `PAR_EN_BIT);
         par_even_q <= 1'(`PAR_CTRL_RST >> `PAR_EVEN_BIT);
      end else begin
         cmp_en_q <= cmp_en_d;
         par_en_q <= par_en_d;
         par_even_q <= par_even_d;
      end
   end

   // ************************************************************
   // per-bit sample compare
   // ************************************************************
   // index 0 port0 rising, 1 port1 rising, 2 port0 falling, 3 port1 falling
   sample_t cmp_err_q [4];
   sample_t cmp_err_d [4];
   sample_t cmp_word [4];
   sample_t cmp_expect [4];
   logic cmp_ev [4];
   assign cmp_word[0] = word0;
   assign cmp_word[1] = word1;
   assign cmp_word[2] = word0;
   assign cmp_word[3] = word1;
   assign cmp_expect[0] = expect_rise_pattern;
   assign cmp_expect[1] = expect_rise_pattern;
   assign cmp_expect[2] = expect_fall_pattern;
   assign cmp_expect[3] = expect_fall_pattern;
   assign cmp_ev[0] = rise_ev;
   assign cmp_ev[1] = rise_ev;
   assign cmp_ev[2] = fall_ev;
   assign cmp_ev[3] = fall_ev;

   always_comb begin
      for (int i = 0; i < 4; i++) begin
         // a miscompare in the clearing cycle survives the clear
         cmp_err_d[i] = cmp_clr ? `CMP_ERR_RST : cmp_err_q[i];
         if (cmp_en_q && cmp_ev[i]) begin
            cmp_err_d[i] = cmp_err_d[i] | (cmp_word[i] ^ cmp_expect[i]);
         end
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         for (int i = 0; i < 4; i++) begin
            cmp_err_q[i] <= `CMP_ERR_RST;
         end
      end else begin
         for (int i = 0; i < 4; i++) begin
            cmp_err_q[i] <= cmp_err_d[i];
         end
      end
   end

   logic cmp_fail;
   assign cmp_fail = |{cmp_err_q[0], cmp_err_q[1], cmp_err_q[2], cmp_err_q[3]};

   // ************************************************************
   // parity check and counters
   // ************************************************************
   logic par_bad_rise, par_bad_fall;
   logic par_flag_rise_q, par_flag_rise_d, par_flag_fall_q, par_flag_fall_d;
   logic [7:0] cnt_rise_q, cnt_rise_d, cnt_fall_q, cnt_fall_d;

   assign par_bad_rise = par_en_q & rise_ev
      & (parity_mismatch(word0, frm0, par_even_q) | parity_mismatch(word1, frm1, par_even_q));
   assign par_bad_fall = par_en_q & fall_ev
      & (parity_mismatch(word0, frm0, par_even_q) | parity_mismatch(word1, frm1, par_even_q));

   always_comb begin
      par_flag_rise_d = (par_flag_rise_q & ~par_clr) | par_bad_rise;
      par_flag_fall_d = (par_flag_fall_q & ~par_clr) | par_bad_fall;
      cnt_rise_d = par_clr ? `PAR_CNT_RST : cnt_rise_q;
      cnt_fall_d = par_clr ? `PAR_CNT_RST : cnt_fall_q;
      // counts clip at full scale so a long burst never wraps back to a small number
      if (par_bad_rise && cnt_rise_d != `PAR_CNT_MAX) begin
         cnt_rise_d = cnt_rise_d + 8'h01;
      end
      if (par_bad_fall && cnt_fall_d != `PAR_CNT_MAX) begin
         cnt_fall_d = cnt_fall_d + 8'h01;
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         par_flag_rise_q <= 1'b0;
         par_flag_fall_q <= 1'b0;
         cnt_rise_q <= `PAR_CNT_RST;
         cnt_fall_q <= `PAR_CNT_RST;
      end else begin
         par_flag_rise_q <= par_flag_rise_d;
         par_flag_fall_q <= par_flag_fall_d;
         cnt_rise_q <= cnt_rise_d;
         cnt_fall_q <= cnt_fall_d;
      end
   end

   // ************************************************************
   // read-back
   // ************************************************************
   always_comb begin
      reg_rdata = 8'h00;
      unique case (reg_addr)
         `ADDR_CMP_CTRL: begin
            reg_rdata[`CMP_EN_BIT] = cmp_en_q;
            reg_rdata[`CMP_FAIL_BIT] = cmp_fail;
         end
         `ADDR_CMP_P0_RISE_LO: reg_rdata = cmp_err_q[0][7:0];
         `ADDR_CMP_P0_RISE_HI: reg_rdata = {2'h0, cmp_err_q[0][13:8]};
         `ADDR_CMP_P1_RISE_LO: reg_rdata = cmp_err_q[1][7:0];
         `ADDR_CMP_P1_RISE_HI: reg_rdata = {2'h0, cmp_err_q[1][13:8]};
         `ADDR_CMP_P0_FALL_LO: reg_rdata = cmp_err_q[2][7:0];
         `ADDR_CMP_P0_FALL_HI: reg_rdata = {2'h0, cmp_err_q[2][13:8]};
         `ADDR_CMP_P1_FALL_LO: reg_rdata = cmp_err_q[3][7:0];
         `ADDR_CMP_P1_FALL_HI: reg_rdata = {2'h0, cmp_err_q[3][13:8]};
         `ADDR_PAR_CTRL: begin
            reg_rdata[`PAR_EN_BIT] = par_en_q;
            reg_rdata[`PAR_EVEN_BIT] = par_even_q;
            reg_rdata[`PAR_ERR_FALL_BIT] = par_flag_fall_q;
            reg_rdata[`PAR_ERR_RISE_BIT] = par_flag_rise_q;
         end
         `ADDR_PAR_CNT_RISE: reg_rdata = cnt_rise_q;
         `ADDR_PAR_CNT_FALL: reg_rdata = cnt_fall_q;
         default: reg_rdata = 8'h00;
      endcase
   end
endmodule : dac_input_link_integrity_check

// >>> test/integrity_assertions.sv
// concurrent checks on the serial register port of the link integrity checker
`timescale 1ns/1ps
module integrity_assertions (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic spi_clk,
   input wire logic spi_cs_n,
   input wire logic spi_sdio_in,
   input wire logic spi_sdio_out,
   input wire logic spi_sdio_oe
);
   // ************************************************************
   // frame decode
   // ************************************************************
   logic [2:0] ck_q;
   logic [2:0] cs_q;
   logic [2:0] di_q;
   logic [4:0] cnt_q;
   logic [4:0] cnt_d;
   logic [7:0] ins_q;
   logic [7:0] ins_d;
   logic rise;
   logic fall;
   assign rise = ck_q[1] & ~ck_q[2];
   assign fall = ~ck_q[1] & ck_q[2];
   always_comb begin
      cnt_d = cnt_q;
      ins_d = ins_q;
      if (cs_q[1]) begin
         cnt_d = 5'h00;
      end else if (rise && cnt_q != 5'h1f) begin
         cnt_d = cnt_q + 5'h01;
         if (cnt_q < 5'h08) begin
            ins_d = {ins_q[6:0], di_q[1]};
         end
      end
   end
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         ck_q <= 3'h0;
         cs_q <= 3'h7;
         di_q <= 3'h0;
         cnt_q <= 5'h00;
         ins_q <= 8'h00;
      end else begin
         ck_q <= {ck_q[1:0], spi_clk};
         cs_q <= {cs_q[1:0], spi_cs_n};
         di_q <= {di_q[1:0], spi_sdio_in};
         cnt_q <= cnt_d;
         ins_q <= ins_d;
      end
   end
   // ************************************************************
   // properties
   // ************************************************************
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   sequence s_rd_phase;
      !spi_cs_n && cnt_q >= 5'h08 && ins_q[7];
   endsequence
   property p_idle; spi_cs_n [*8] |-> !spi_sdio_oe; endproperty
   a_idle: assert property (p_idle) else $error("sdio driven while deselected");
   property p_wr_quiet; !spi_cs_n && cnt_q >= 5'h08 && !ins_q[7] |-> !spi_sdio_oe; endproperty
   a_wr_quiet: assert property (p_wr_quiet) else $error("sdio driven in a write frame");
   property p_rd_oe; s_rd_phase ##0 (fall && cnt_q == 5'h08) |-> ##[0:6] spi_sdio_oe; endproperty
   a_rd_oe: assert property (p_rd_oe) else $error("read data not driven");
   property p_oe_fell; $fell(spi_sdio_oe) |-> spi_cs_n && $past(spi_cs_n, 2); endproperty
   a_oe_fell: assert property (p_oe_fell) else $error("sdio released inside a frame");
   property p_oe_drop; $rose(spi_cs_n) && spi_sdio_oe |-> ##[1:6] !spi_sdio_oe; endproperty
   a_oe_drop: assert property (p_oe_drop) else $error("sdio not released after deselect");
   property p_out_stable; spi_sdio_oe && rise |-> $stable(spi_sdio_out); endproperty
   a_out_stable: assert property (p_out_stable) else $error("read data moved at sampling edge");
   property p_rsv_hi;
      s_rd_phase ##0 (rise && cnt_q inside {5'h08, 5'h09} && ins_q[6:0] inside {7'h54, 7'h56, 7'h58})
         |-> !spi_sdio_out;
   endproperty
   a_rsv_hi: assert property (p_rsv_hi) else $error("upper status bits 7..6 not zero");
   property p_self_clr;
      s_rd_phase ##0 (rise && ((ins_q[6:0] == 7'h50 && cnt_q == 5'h09) ||
         (ins_q[6:0] == 7'h5c && cnt_q inside {[5'h0a:5'h0d]}))) |-> !spi_sdio_out;
   endproperty
   a_self_clr: assert property (p_self_clr) else $error("clear or reserved bit read as one");
   property p_unmapped; s_rd_phase ##0 (rise && ins_q[6:0] == 7'h59 && cnt_q < 5'h10) |-> !spi_sdio_out;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
endmodule : integrity_assertions

bind dac_input_link_integrity_check integrity_assertions chk (.ref_clk(ref_clk), .nrst(nrst),
   .spi_clk(spi_clk), .spi_cs_n(spi_cs_n), .spi_sdio_in(spi_sdio_in), .spi_sdio_out(spi_sdio_out),
   .spi_sdio_oe(spi_sdio_oe));

// >>> test/host_link_model.sv
// host side model: drives ddr sample words with frame parity
`timescale 1ns/1ps
module host_link_model (
   input wire logic run,
   input wire logic even_sense,
   input wire logic [1:0] bad_rise,
   input wire logic [1:0] bad_fall,
   input wire logic [13:0] w0_rise,
   input wire logic [13:0] w1_rise,
   input wire logic [13:0] w0_fall,
   input wire logic [13:0] w1_fall,
   output logic link_clk,
   output logic [13:0] port0_data,
   output logic [13:0] port1_data,
   output logic port0_par,
   output logic port1_par
);
   function automatic logic par_of(input logic [13:0] w, input logic ev, input logic bad);
      return (ev ? ~^w : ^w) ^ bad;
   endfunction : par_of
   task automatic put(input logic [13:0] a, input logic [13:0] b, input logic [1:0] bad);
      port0_data = a;
      port1_data = b;
      port0_par = par_of(a, even_sense, bad[0]);
      port1_par = par_of(b, even_sense, bad[1]);
   endtask : put
   // words change 20 ns away from each clock edge, so setup and hold are both met
   initial begin
      link_clk = 1'b0;
      put(14'h0000, 14'h0000, 2'b00);
      forever begin
         if (!run) begin
            // idle lines show the inverse so a stale word is never taken as fresh
            #20 put(~port0_data, ~port1_data, 2'b11);
            wait (run);
            // step off the sampling edge so pins never change at a ref_clk rise
            #1;
         end
         #20 put(w0_rise, w1_rise, bad_rise);
         #20 link_clk = 1'b1;
         #20 put(w0_fall, w1_fall, bad_fall);
         #20 link_clk = 1'b0;
      end
   end
endmodule : host_link_model

// >>> test/tb.sv
// self-checking bench for the link integrity checker
`timescale 1ns/1ps
module tb;
   logic ref_clk = 1'b0;
   logic nrst = 1'b0;
   logic spi_clk = 1'b0;
   logic spi_cs_n = 1'b1;
   logic mst_oe = 1'b1;
   logic mst_bit = 1'b0;
   logic run = 1'b0;
   logic even = 1'b1;
   logic [1:0] bad_r = 2'b00;
   logic [1:0] bad_f = 2'b00;
   logic [13:0] exp_r = 14'h0000;
   logic [13:0] exp_f = 14'h0000;
   logic [13:0] w0r = 14'h0000;
   logic [13:0] w1r = 14'h0000;
   logic [13:0] w0f = 14'h0000;
   logic [13:0] w1f = 14'h0000;
   logic link_clk;
   logic [13:0] p0;
   logic [13:0] p1;
   logic par0;
   logic par1;
   logic spi_sdio_in;
   logic spi_sdio_out;
   logic spi_sdio_oe;
   int fails = 0;
   int comparisons = 0;
   int cycles = 0;
   // a released sdio shows the inverse of the master's last bit
   assign spi_sdio_in = spi_sdio_oe ? spi_sdio_out : (mst_oe ? mst_bit : ~mst_bit);
   always #2 ref_clk = ~ref_clk;
   dac_input_link_integrity_check uut (.ref_clk(ref_clk), .nrst(nrst), .link_clk(link_clk), .port0_data(p0),
      .port1_data(p1), .port0_frame_parity_pin(par0), .port1_frame_parity_pin(par1), .expect_rise_pattern(exp_r),
      .expect_fall_pattern(exp_f), .spi_clk(spi_clk), .spi_cs_n(spi_cs_n), .spi_sdio_in(spi_sdio_in),
      .spi_sdio_out(spi_sdio_out), .spi_sdio_oe(spi_sdio_oe));
   host_link_model hm (.run(run), .even_sense(even), .bad_rise(bad_r), .bad_fall(bad_f), .w0_rise(w0r),
      .w1_rise(w1r), .w0_fall(w0f), .w1_fall(w1f), .link_clk(link_clk), .port0_data(p0), .port1_data(p1),
      .port0_par(par0), .port1_par(par1));
   // ************************************************************
   // bus and link tasks
   // ************************************************************
   task automatic xfer(input logic rd, input logic [6:0] a, input logic [7:0] wd, output logic [7:0] rv);
      logic [15:0] sh;
      sh = {rd, a, wd};
      rv = 8'h00;
      @(posedge ref_clk) spi_cs_n <= 1'b0;
      for (int i = 15; i >= 0; i--) begin
         mst_oe <= !(rd && i < 8);
         mst_bit <= sh[i];
         repeat (10) @(posedge ref_clk);
         spi_clk <= 1'b1;
         if (i < 8) rv[i] = spi_sdio_in;
         repeat (10) @(posedge ref_clk);
         spi_clk <= 1'b0;
      end
      repeat (10) @(posedge ref_clk);
      spi_cs_n <= 1'b1;
      mst_oe <= 1'b1;
      repeat (10) @(posedge ref_clk);
   endtask : xfer
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      logic [7:0] nul;
      xfer(1'b0, a, d, nul);
   endtask : wr
   task automatic rchk(input logic [6:0] a, input logic [7:0] exp);
      logic [7:0] got;
      xfer(1'b1, a, 8'h00, got);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] t=%0t reg %h got %h exp %h", $time, a, got, exp);
      end
   endtask : rchk
   // run n whole link clock periods; run drops mid-period so the count is exact
   task automatic link(input int n);
      @(posedge ref_clk) run <= 1'b1;
      repeat (n * 20 - 10) @(posedge ref_clk);
      run <= 1'b0;
      repeat (40) @(posedge ref_clk);
   endtask : link
   // ************************************************************
   // scenarios
   // ************************************************************
   task automatic t_reset;
      for (int a = 'h50; a <= 'h5e; a++) rchk(7'(a), 8'h00);
      wr(7'h55, 8'hff);
      wr(7'h5d, 8'hff);
      rchk(7'h55, 8'h00);
      rchk(7'h5d, 8'h00);
      wr(7'h5c, 8'hff);
      rchk(7'h5c, 8'hc0);
      wr(7'h5c, 8'h00);
      $display("t_reset done");
   endtask : t_reset
   task automatic t_cmp;
      exp_r <= 14'h1555;
      exp_f <= 14'h2aaa;
      w0r <= 14'h1555 ^ 14'h0004;
      w1r <= 14'h1555 ^ 14'h2101;
      w0f <= 14'h2aaa ^ 14'h2080;
      w1f <= 14'h2aaa ^ 14'h3f01;
      link(2);
      rchk(7'h53, 8'h00);
      wr(7'h50, 8'h80);
      link(2);
      w0r <= 14'h1555;
      w1r <= 14'h1555;
      w0f <= 14'h2aaa;
      w1f <= 14'h2aaa;
      link(2);
      rchk(7'h51, 8'h04);
      rchk(7'h52, 8'h00);
      rchk(7'h53, 8'h01);
      rchk(7'h54, 8'h21);
      rchk(7'h55, 8'h80);
      rchk(7'h56, 8'h20);
      rchk(7'h57, 8'h01);
      rchk(7'h58, 8'h3f);
      rchk(7'h50, 8'h81);
      wr(7'h50, 8'hc0);
      for (int a = 'h51; a <= 'h58; a++) rchk(7'(a), 8'h00);
      rchk(7'h50, 8'h80);
      $display("t_cmp done");
   endtask : t_cmp
   task automatic t_par;
      bad_r <= 2'b01;
      link(3);
      rchk(7'h5d, 8'h00);
      wr(7'h5c, 8'hc0);
      bad_r <= 2'b00;
      link(2);
      rchk(7'h5d, 8'h00);
      bad_r <= 2'b01;
      link(3);
      rchk(7'h5d, 8'h03);
      rchk(7'h5e, 8'h00);
      rchk(7'h5c, 8'hc1);
      wr(7'h5c, 8'h80);
      even <= 1'b0;
      bad_r <= 2'b00;
      bad_f <= 2'b10;
      link(2);
      rchk(7'h5e, 8'h02);
      rchk(7'h5d, 8'h03);
      rchk(7'h5c, 8'h83);
      bad_r <= 2'b11;
      bad_f <= 2'b00;
      link(2);
      rchk(7'h5d, 8'h05);
      wr(7'h5c, 8'ha0);
      rchk(7'h5d, 8'h00);
      rchk(7'h5e, 8'h00);
      bad_r <= 2'b01;
      link(258);
      rchk(7'h5d, 8'hff);
      rchk(7'h5e, 8'h00);
      $display("t_par done");
   endtask : t_par
   task automatic conclude;
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : conclude
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 60000) begin
         fails++;
         $display("[FAIL] t=%0t timeout got %h exp %h", $time, cycles, 0);
         conclude();
      end
   end
   initial begin
      repeat (4) @(posedge ref_clk);
      nrst <= 1'b1;
      repeat (4) @(posedge ref_clk);
      t_reset();
      t_cmp();
      t_par();
      conclude();
   end
endmodule : tb
